// ### rsnv_regs.svh
`ifndef RSNV_REGS_SVH
`define RSNV_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RSNV_ADDR_USER_NMI_VECTOR 16'h015A
`define RSNV_ADDR_SYSTEM_NMI_VECTOR 16'h015C
`define RSNV_ADDR_RESET_CAUSE_VECTOR 16'h015E
`define RSNV_ADDR_MAILBOX_STATUS 16'h0146
`define RSNV_ADDR_MAILBOX_IN 16'h0148
`define RSNV_ADDR_MAILBOX_OUT 16'h014C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RSNV_MBSTAT_IN_FULL_BIT 0
`define RSNV_MBSTAT_OUT_FULL_BIT 1
`define RSNV_WORD_RESET 16'h0000
`define RSNV_NO_PENDING_CODE 8'h00

// ----------------------------------------------------------------------------
// Source counts
// ----------------------------------------------------------------------------
`define RSNV_RST_SRC_N 14
`define RSNV_SNMI_SRC_N 6
`define RSNV_UNMI_SRC_N 2
`define RSNV_TAB_N 14

// ----------------------------------------------------------------------------
// Vector codes, index 13 first, index 0 last (index 0 has the highest priority)
// ----------------------------------------------------------------------------
`define RSNV_RST_CODES {8'h24, 8'h20, 8'h1E, 8'h1C, 8'h1A, 8'h18, 8'h16, \
  8'h14, 8'h0E, 8'h0A, 8'h08, 8'h06, 8'h04, 8'h02}
`define RSNV_SNMI_CODES {64'h0, 8'h18, 8'h16, 8'h14, 8'h12, 8'h04, 8'h02}
`define RSNV_UNMI_CODES {96'h0, 8'h04, 8'h02}

// ----------------------------------------------------------------------------
// Reset class of each reset cause, bit i belongs to cause index i
// ----------------------------------------------------------------------------
`define RSNV_CLASS_BOR_MASK 14'h003F
`define RSNV_CLASS_POR_MASK 14'h0040
`define RSNV_CLASS_PUC_MASK 14'h3F80

// ----------------------------------------------------------------------------
// Fixed source positions inside the system NMI flags
// ----------------------------------------------------------------------------
`define RSNV_SNMI_MB_IN_IDX 3
`define RSNV_SNMI_MB_OUT_IDX 4

`endif

// ### rsnv_pkg.sv
package rsnv_pkg;
  `include "rsnv_regs.svh"

  // Reset cause events, one-cycle pulses, lowest priority first (supply_brownout, index 0, is the highest).
  typedef struct packed {
    logic fll_unlock;
    logic power_management_key_fault;
    logic peripheral_fetch;
    logic memory_uncorrectable;
    logic memory_controller_key_fault;
    logic watchdog_key_fault;
    logic watchdog_expiry_flag;
    logic software_power_on_request;
    logic high_supply_supervisor_flag;
    logic security_violation;
    logic retention_low_power_mode_wake;
    logic software_brownout_request;
    logic reset_pin_flag;
    logic supply_brownout;
  } rsnv_rst_ev_t;

  // System and user NMI events coming from outside the block.
  typedef struct packed {
    logic memory_correctable;
    logic vacant_access_flag;
    logic memory_uncorrectable;
    logic low_power_reset_entry;
    logic oscillator_fault_flag;
    logic nmi_pin_flag;
  } rsnv_nmi_ev_t;

  // Register bus request.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rsnv_bus_t;

  // Debugger side of the mailbox.
  typedef struct packed {
    logic [15:0] in_data;
    logic in_wr;
    logic out_rd;
  } rsnv_dbg_t;

  // Reset class requests.
  typedef struct packed {
    logic brownout_class_reset;
    logic power_on_reset;
    logic power_up_clear_reset;
  } rsnv_class_t;

  // Result of a priority pick.
  typedef struct packed {
    logic [7:0] code;
    logic [13:0] onehot;
  } rsnv_pick_t;

  // Whole state of the block.
  typedef struct packed {
    logic [13:0] rst_flag;
    logic [5:0] snmi_flag;
    logic [1:0] unmi_flag;
    logic [15:0] mb_in;
    logic [15:0] mb_out;
    logic mb_in_full;
    logic mb_out_full;
    logic [15:0] rdata;
    rsnv_class_t cls;
  } rsnv_state_t;
endpackage

// ### rsnv_top.sv
`timescale 1ns/100ps
module rsnv_top (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire rsnv_pkg::rsnv_bus_t bus_in,
  output logic [15:0] bus_rdata_out,
  input wire rsnv_pkg::rsnv_rst_ev_t reset_cause_in,
  input wire rsnv_pkg::rsnv_nmi_ev_t nmi_event_in,
  input wire rsnv_pkg::rsnv_dbg_t dbg_in,
  output logic [15:0] dbg_out_data_out,
  output logic dbg_out_valid_out,
  output logic dbg_in_full_out,
  output rsnv_pkg::rsnv_class_t reset_class_out
);
  import rsnv_pkg::*;

  // --------------------------------------------------------------------------
  // Code tables
  // --------------------------------------------------------------------------
  localparam logic [111:0] RST_TAB = `RSNV_RST_CODES;
  localparam logic [111:0] SNMI_TAB = `RSNV_SNMI_CODES;
  localparam logic [111:0] UNMI_TAB = `RSNV_UNMI_CODES;

  rsnv_state_t st_r;
  rsnv_state_t st_nxt;
  rsnv_pick_t rst_pick;
  rsnv_pick_t snmi_pick;
  rsnv_pick_t unmi_pick;
  logic [13:0] rst_set;
  logic [5:0] snmi_set;
  logic [1:0] unmi_set;
  logic [13:0] rst_clr;
  logic [5:0] snmi_clr;
  logic [1:0] unmi_clr;
  logic rd_rst;
  logic rd_snmi;
  logic rd_unmi;
  logic cpu_in_rd;
  logic cpu_out_wr;
  logic dbg_take;
  logic dbg_put;

  // --------------------------------------------------------------------------
  // Priority pick
  // --------------------------------------------------------------------------
  // Scanning downward lets the lowest index, which holds the lowest code,
  // overwrite the others, so the most urgent source always wins.
  function automatic rsnv_pick_t rsnv_pick(input logic [13:0] flags,
                                           input logic [111:0] tab);
    rsnv_pick_t p;
    p.code = `RSNV_NO_PENDING_CODE;
    p.onehot = '0;
    for (int i = 13; i >= 0; i--) begin
      if (flags[i]) begin
        p.code = tab[i*8 +: 8];
        p.onehot = 14'(1) << i;
      end
    end
    return p;
  endfunction

  // Each vector looks only at its own flags; unused table slots never fire.
  always_comb begin
    rst_pick = rsnv_pick(st_r.rst_flag, RST_TAB);
    snmi_pick = rsnv_pick({8'h00, st_r.snmi_flag}, SNMI_TAB);
    unmi_pick = rsnv_pick({12'h000, st_r.unmi_flag}, UNMI_TAB);
  end

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // A read takes the flag of whatever the vector reports in that cycle.
  assign rd_rst = bus_in.rd && (bus_in.addr == `RSNV_ADDR_RESET_CAUSE_VECTOR);
  assign rd_snmi = bus_in.rd && (bus_in.addr == `RSNV_ADDR_SYSTEM_NMI_VECTOR);
  assign rd_unmi = bus_in.rd && (bus_in.addr == `RSNV_ADDR_USER_NMI_VECTOR);
  assign cpu_in_rd = bus_in.rd && (bus_in.addr == `RSNV_ADDR_MAILBOX_IN);
  assign cpu_out_wr = bus_in.wr && (bus_in.addr == `RSNV_ADDR_MAILBOX_OUT);
  assign rst_clr = rd_rst ? rst_pick.onehot : '0;
  assign snmi_clr = rd_snmi ? snmi_pick.onehot[5:0] : '0;
  assign unmi_clr = rd_unmi ? unmi_pick.onehot[1:0] : '0;

  // --------------------------------------------------------------------------
  // Mailbox handshakes
  // --------------------------------------------------------------------------
  // The debugger may only take a word that is there; a put is always
  // accepted and overwrites, so a slow reader loses the older word.
  assign dbg_take = dbg_in.out_rd && st_r.mb_out_full;
  assign dbg_put = dbg_in.in_wr;

  // --------------------------------------------------------------------------
  // Event sources
  // --------------------------------------------------------------------------
  always_comb begin
    rst_set = reset_cause_in;
    snmi_set = '0;
    snmi_set[0] = nmi_event_in.low_power_reset_entry;
    snmi_set[1] = nmi_event_in.memory_uncorrectable;
    snmi_set[2] = nmi_event_in.vacant_access_flag;
    snmi_set[`RSNV_SNMI_MB_IN_IDX] = dbg_put;
    snmi_set[`RSNV_SNMI_MB_OUT_IDX] = dbg_take;
    snmi_set[5] = nmi_event_in.memory_correctable;
    unmi_set = {nmi_event_in.oscillator_fault_flag, nmi_event_in.nmi_pin_flag};
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Sticky flags: a new event in the clearing cycle is kept, set wins.
    st_nxt.rst_flag = (st_r.rst_flag & ~rst_clr) | rst_set;
    st_nxt.snmi_flag = (st_r.snmi_flag & ~snmi_clr) | snmi_set;
    st_nxt.unmi_flag = (st_r.unmi_flag & ~unmi_clr) | unmi_set;
    // Every arriving cause asks for its own class of reset.
    st_nxt.cls.brownout_class_reset = |(rst_set & `RSNV_CLASS_BOR_MASK);
    st_nxt.cls.power_on_reset = |(rst_set & `RSNV_CLASS_POR_MASK);
    st_nxt.cls.power_up_clear_reset = |(rst_set & `RSNV_CLASS_PUC_MASK);
    // Incoming slot: debugger writes, software reads and frees it.
    if (dbg_put) begin
      st_nxt.mb_in = dbg_in.in_data;
      st_nxt.mb_in_full = 1'b1;
    end else if (cpu_in_rd) begin
      st_nxt.mb_in_full = 1'b0;
    end
    // Outgoing slot: software writes, debugger takes and frees it.
    if (cpu_out_wr) begin
      st_nxt.mb_out = bus_in.wdata;
      st_nxt.mb_out_full = 1'b1;
    end else if (dbg_take) begin
      st_nxt.mb_out_full = 1'b0;
    end
    // Read data stand only in the cycle after the read strobe.
    st_nxt.rdata = `RSNV_WORD_RESET;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        `RSNV_ADDR_RESET_CAUSE_VECTOR: st_nxt.rdata = {8'h00, rst_pick.code};
        `RSNV_ADDR_SYSTEM_NMI_VECTOR: st_nxt.rdata = {8'h00, snmi_pick.code};
        `RSNV_ADDR_USER_NMI_VECTOR: st_nxt.rdata = {8'h00, unmi_pick.code};
        `RSNV_ADDR_MAILBOX_IN: st_nxt.rdata = st_r.mb_in;
        `RSNV_ADDR_MAILBOX_OUT: st_nxt.rdata = st_r.mb_out;
        `RSNV_ADDR_MAILBOX_STATUS: st_nxt.rdata = {14'h0000, st_r.mb_out_full,
                                                   st_r.mb_in_full};
        default: st_nxt.rdata = `RSNV_WORD_RESET;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Writes to the vector words are ignored: they are read-only.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign bus_rdata_out = st_r.rdata;
  assign dbg_out_data_out = st_r.mb_out;
  assign dbg_out_valid_out = st_r.mb_out_full;
  assign dbg_in_full_out = st_r.mb_in_full;
  assign reset_class_out = st_r.cls;
endmodule

// ### rsnv_top_properties.sv
`timescale 1ns/100ps
`include "rsnv_regs.svh"
module rsnv_top_properties (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire rsnv_pkg::rsnv_bus_t bus_in,
  input wire logic [15:0] bus_rdata_out,
  input wire rsnv_pkg::rsnv_rst_ev_t reset_cause_in,
  input wire rsnv_pkg::rsnv_dbg_t dbg_in,
  input wire logic [15:0] dbg_out_data_out,
  input wire logic dbg_out_valid_out,
  input wire logic dbg_in_full_out,
  input wire rsnv_pkg::rsnv_class_t reset_class_out
);
  import rsnv_pkg::*;
  // ----------
  // Checks
  // ----------
  // One clock domain, so clock and reset are stated once for every property.
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic vec_rd_r;
  // Remembers a vector read, because the mailbox words may use the upper byte.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) vec_rd_r <= 1'b0;
    else vec_rd_r <= bus_in.rd && bus_in.addr inside {`RSNV_ADDR_USER_NMI_VECTOR,
      `RSNV_ADDR_SYSTEM_NMI_VECTOR, `RSNV_ADDR_RESET_CAUSE_VECTOR};
  end
  property p_idle_rdata; !$past(bus_in.rd) |-> bus_rdata_out == 16'h0000; endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside slot");
  property p_code_form; vec_rd_r |-> bus_rdata_out[15:8] == 8'h00 && !bus_rdata_out[0];
  endproperty
  a_code_form: assert property (p_code_form) else $error("vector code malformed");
  property p_por; reset_cause_in.software_power_on_request |=> reset_class_out.power_on_reset;
  endproperty
  a_por: assert property (p_por) else $error("power-on class missing");
  property p_wdog; reset_cause_in.watchdog_expiry_flag |=> reset_class_out.power_up_clear_reset;
  endproperty
  a_wdog: assert property (p_wdog) else $error("clear class missing on expiry");
  property p_wkey; reset_cause_in.watchdog_key_fault |=> reset_class_out.power_up_clear_reset;
  endproperty
  a_wkey: assert property (p_wkey) else $error("clear class missing on key");
  property p_bor; |reset_cause_in[5:0] |=> reset_class_out.brownout_class_reset; endproperty
  a_bor: assert property (p_bor) else $error("brownout class missing");
  property p_fetch; reset_cause_in[13:11] != 3'h0 |=> reset_class_out.power_up_clear_reset;
  endproperty
  a_fetch: assert property (p_fetch) else $error("clear class missing");
  property p_cls; reset_class_out.power_on_reset |-> $past(reset_cause_in[6]); endproperty
  a_cls: assert property (p_cls) else $error("power-on class without cause");
  property p_mb_in; dbg_in.in_wr |=> dbg_in_full_out; endproperty
  a_mb_in: assert property (p_mb_in) else $error("incoming slot not full");
  property p_mb_out; dbg_in.out_rd && dbg_out_valid_out && !(bus_in.wr &&
    bus_in.addr == `RSNV_ADDR_MAILBOX_OUT) |=> !dbg_out_valid_out; endproperty
  a_mb_out: assert property (p_mb_out) else $error("outgoing slot not emptied");
  property p_mb_wr; bus_in.wr && bus_in.addr == `RSNV_ADDR_MAILBOX_OUT |=>
    dbg_out_valid_out && dbg_out_data_out == $past(bus_in.wdata); endproperty
  a_mb_wr: assert property (p_mb_wr) else $error("outgoing word lost");
  cover property (vec_rd_r && bus_rdata_out != 16'h0000);
  cover property (dbg_in.out_rd && dbg_out_valid_out);
  cover property (reset_class_out.power_on_reset);
endmodule
bind rsnv_top rsnv_top_properties rsnv_top_properties_inst (.ref_clk_in, .rst_n_in,
  .bus_in, .bus_rdata_out, .reset_cause_in, .dbg_in, .dbg_out_data_out,
  .dbg_out_valid_out, .dbg_in_full_out, .reset_class_out);

// ### rsnv_dbg_model.sv
`timescale 1ns/100ps
module rsnv_dbg_model (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic put_in,
  input wire logic [15:0] put_data_in,
  input wire logic stall_in,
  input wire logic valid_in,
  input wire logic [15:0] data_in,
  output rsnv_pkg::rsnv_dbg_t dbg_out,
  output logic took_out,
  output logic [15:0] took_data_out
);
  import rsnv_pkg::*;
  // Debugger end: puts a word on request and takes a full outgoing slot unless stalled.
  // Between puts the data lines flip, so a stale word can never pass as a fresh one.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dbg_out <= '0;
      took_out <= 1'b0;
      took_data_out <= 16'h0000;
    end else begin
      dbg_out.in_wr <= put_in;
      dbg_out.in_data <= put_in ? put_data_in : ~dbg_out.in_data;
      dbg_out.out_rd <= valid_in && !dbg_out.out_rd && !stall_in;
      took_out <= dbg_out.out_rd && valid_in;
      took_data_out <= data_in;
    end
  end
endmodule

// ### tb_rsnv_top.sv
`timescale 1ns/100ps
`include "rsnv_regs.svh"
module tb_rsnv_top;
  import rsnv_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  rsnv_bus_t bus = '0;
  rsnv_rst_ev_t cause = '0;
  rsnv_nmi_ev_t nmi = '0;
  rsnv_dbg_t dbg;
  rsnv_class_t cls;
  logic [15:0] rdata, mb_data, took_data, w;
  logic mb_valid, in_full, took;
  logic put = 1'b0, stall = 1'b0, rd_d = 1'b0;
  logic [15:0] put_data = 16'h0000, rnd = 16'h0028;
  logic [13:0] m;
  logic [5:0] n;
  logic [15:0] exp_q[$], mb_q[$];
  int errors = 0;
  int checks_done = 0;
  rsnv_top rsnv_top_inst (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .bus_in(bus),
    .bus_rdata_out(rdata), .reset_cause_in(cause), .nmi_event_in(nmi), .dbg_in(dbg),
    .dbg_out_data_out(mb_data), .dbg_out_valid_out(mb_valid), .dbg_in_full_out(in_full),
    .reset_class_out(cls));
  rsnv_dbg_model rsnv_dbg_model_inst (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .put_in(put),
    .put_data_in(put_data), .stall_in(stall), .valid_in(mb_valid), .data_in(mb_data),
    .dbg_out(dbg), .took_out(took), .took_data_out(took_data));
  // ----------
  // Drivers and scoreboard
  // ----------
  always #2 ref_clk = ~ref_clk;
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask
  // Every input is set once per edge, so back-to-back calls never race each other.
  task automatic drive(input rsnv_bus_t b, input rsnv_rst_ev_t c, input rsnv_nmi_ev_t e,
    input logic p, input logic [15:0] x);
    @(posedge ref_clk);
    bus <= b;
    cause <= c;
    nmi <= e;
    put <= p;
    put_data <= rnd;
    if (b.rd) exp_q.push_back(x);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] x);
    drive({a, 16'h0000, 1'b0, 1'b1}, '0, '0, 1'b0, x);
  endtask
  task automatic idle(input int k);
    repeat (k) drive('0, '0, '0, 1'b0, 16'h0000);
  endtask
  // Reads one vector until empty, expecting pending codes in table order.
  task automatic drain(input logic [15:0] a, input logic [13:0] s, input logic [111:0] t);
    for (int i = 0; i < 14; i++) begin
      if (s[i]) rd(a, {8'h00, t[i*8 +: 8]});
    end
    rd(a, 16'h0000);
  endtask
  // The answer stands only in the cycle after the strobe, so it is judged there.
  always @(posedge ref_clk) rd_d <= bus.rd;
  always @(negedge ref_clk) begin
    if (rd_d) check(rdata, exp_q.pop_front());
    if (took) check(took_data, mb_q.pop_front());
  end
  task automatic give_verdict();
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`RSNV_ADDR_SYSTEM_NMI_VECTOR, 16'h0000);
    rd(`RSNV_ADDR_USER_NMI_VECTOR, 16'h0000);
    rd(16'h0150, 16'h0000);
    drive({`RSNV_ADDR_RESET_CAUSE_VECTOR, 16'hFFFF, 1'b1, 1'b0}, '0, '0, 1'b0, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      m = (k == 0) ? 14'h3FFF : rnd[13:0];
      n = (k == 0) ? 6'h3F : lf(rnd);
      drive('0, m, n, 1'b0, 16'h0000);
      idle(1);
      drain(`RSNV_ADDR_RESET_CAUSE_VECTOR, m, {8'h24, 8'h20, 8'h1E, 8'h1C, 8'h1A, 8'h18,
        8'h16, 8'h14, 8'h0E, 8'h0A, 8'h08, 8'h06, 8'h04, 8'h02});
      drain(`RSNV_ADDR_SYSTEM_NMI_VECTOR, {10'h000, n[5:2]},
        {80'h0, 8'h18, 8'h12, 8'h04, 8'h02});
      drain(`RSNV_ADDR_USER_NMI_VECTOR, {12'h000, n[1:0]}, {96'h0, 8'h04, 8'h02});
      rnd = lf(lf(rnd));
    end
    // A debugger word arrives, is read by software, and leaves its event behind.
    w = rnd;
    drive('0, '0, '0, 1'b1, 16'h0000);
    idle(2);
    rd(`RSNV_ADDR_MAILBOX_STATUS, 16'h0001);
    rd(`RSNV_ADDR_MAILBOX_IN, w);
    rd(`RSNV_ADDR_MAILBOX_STATUS, 16'h0000);
    drain(`RSNV_ADDR_SYSTEM_NMI_VECTOR, 14'h0001, {104'h0, 8'h14});
    // Outgoing word is held while the debugger stalls, then taken.
    w = ~rnd;
    mb_q.push_back(w);
    drive({`RSNV_ADDR_MAILBOX_OUT, w, 1'b1, 1'b0}, '0, '0, 1'b0, 16'h0000);
    stall <= 1'b1;
    idle(1);
    rd(`RSNV_ADDR_MAILBOX_STATUS, 16'h0002);
    stall <= 1'b0;
    idle(4);
    drain(`RSNV_ADDR_SYSTEM_NMI_VECTOR, 14'h0001, {104'h0, 8'h16});
    idle(3);
    give_verdict();
  end
endmodule
